/* File: design/quad_dac_device.sv */
// quad converter digital front end: serial port, load strobe, clear and code interpretation
`include "quad_dac_map.svh"
`default_nettype none
module quad_dac_device (
   input  wire logic                       clock,
   input  wire logic                       sys_rst,
   input  wire logic                       clk_en,
   quad_dac_link.device                    link,
   input  wire logic                       coding_select,
   input  wire logic                       bipolar_range,
   input  wire logic                       clear_to_mid,
   output logic [`CHANNELS-1:0][15:0]      chan_code,
   output logic [`CHANNELS-1:0][15:0]      chan_level,
   output logic                            write_done,
   output logic                            frame_error
);

   localparam quad_dac_pkg::code_t RES_MASK =
      quad_dac_pkg::code_t'(16'hffff << (`DATA_BITS - `RESOLUTION));

   // ---------------- link clock domain ----------------
   logic [4:0]           bit_cnt_r;
   quad_dac_pkg::word_t  shift_r;
   quad_dac_pkg::word_t  frame_word_r;
   logic                 frame_ok_r;
   logic                 serial_out_r;

   // count saturates past 24 so any overrun is still seen at the frame end
   always_ff @(negedge link.sclk or posedge link.frame_n) begin
      if (link.frame_n) begin
         bit_cnt_r <= 5'h00;                                       // RULE1
      end else if (bit_cnt_r != `BIT_COUNT_LIMIT) begin
         bit_cnt_r <= bit_cnt_r + 5'h01;
      end
   end

   always_ff @(negedge link.sclk) begin
      if (!link.frame_n) begin
         shift_r <= {shift_r[`WORD_BITS-2:0], link.serial_in};     // RULE2
      end
   end

   // the frame's own rising edge holds the word until the next frame ends
   always_ff @(posedge link.frame_n) begin
      frame_word_r <= shift_r;                                     // RULE3
      frame_ok_r   <= (bit_cnt_r == `BIT_COUNT_FULL);              // RULE17
   end

   // parked low between frames so the pin never floats at an unknown level
   always_ff @(posedge link.sclk or posedge link.frame_n) begin
      if (link.frame_n) begin
         serial_out_r <= 1'b0;
      end else begin
         serial_out_r <= shift_r[`WORD_BITS-1];                    // RULE15
      end
   end

   assign link.serial_out = serial_out_r;

   // ---------------- system clock domain ----------------
   logic  frame_s1_r;
   logic  frame_s2_r;
   logic  frame_s3_r;
   logic  load_s1_r;
   logic  load_s2_r;
   logic  load_s3_r;
   logic  clear_s1_r;
   logic  clear_s2_r;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         frame_s1_r <= 1'b1;
         frame_s2_r <= 1'b1;
         frame_s3_r <= 1'b1;
      end else if (clk_en) begin
         frame_s1_r <= link.frame_n;
         frame_s2_r <= frame_s1_r;
         frame_s3_r <= frame_s2_r;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         load_s1_r <= 1'b1;
         load_s2_r <= 1'b1;
         load_s3_r <= 1'b1;
      end else if (clk_en) begin
         load_s1_r <= link.load_strobe_n;
         load_s2_r <= load_s1_r;
         load_s3_r <= load_s2_r;
      end
   end

   // clear is watched on the system clock so it works with the serial clock stopped
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         clear_s1_r <= 1'b1;
         clear_s2_r <= 1'b1;
      end else if (clk_en) begin
         clear_s1_r <= link.clear_n;
         clear_s2_r <= clear_s1_r;
      end
   end

   // the coding pin is strapped on the board; two flops keep a slow edge from splitting channels
   logic  coding_s1_r;
   logic  coding_s2_r;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         coding_s1_r <= 1'b1;
         coding_s2_r <= 1'b1;
      end else if (clk_en) begin
         coding_s1_r <= coding_select;
         coding_s2_r <= coding_s1_r;
      end
   end

   logic                 frame_rise;
   logic                 load_fall;
   logic                 load_low;
   logic                 clear_act;
   logic                 twos_mode;
   logic                 write_hit;
   logic [2:0]           addr_field;
   quad_dac_pkg::code_t  data_field;
   quad_dac_pkg::code_t  clear_code;

   assign frame_rise = frame_s2_r & ~frame_s3_r;
   assign load_fall  = ~load_s2_r & load_s3_r;
   assign load_low   = ~load_s2_r;
   assign clear_act  = ~clear_s2_r;

   assign twos_mode  = bipolar_range & ~coding_s2_r;              // RULE11 RULE12

   // only a well-formed write to the converter data register lands
   assign write_hit  = frame_rise & frame_ok_r & ~frame_word_r[`RW_BIT]
                       & (frame_word_r[`REG_MSB:`REG_LSB] == `REG_SEL_CONV);  // RULE16 RULE17
   assign addr_field = frame_word_r[`ADDR_MSB:`ADDR_LSB];
   assign data_field = frame_word_r[`DATA_BITS-1:0] & RES_MASK;  // RULE21

   always_comb begin
      if (clear_to_mid) begin
         clear_code = twos_mode ? (`CODE_STRAIGHT_MS ^ `SIGN_FLIP) : `CODE_STRAIGHT_MS;  // RULE13
      end else begin
         clear_code = twos_mode ? (`CODE_STRAIGHT_ZS ^ `SIGN_FLIP) : `CODE_STRAIGHT_ZS;  // RULE14
      end
   end

   quad_dac_pkg::code_t  in_reg_r  [`CHANNELS];
   quad_dac_pkg::code_t  conv_reg_r[`CHANNELS];

   genvar ch;
   generate
      for (ch = 0; ch < `CHANNELS; ch = ch + 1) begin : g_chan
         logic                 sel;
         quad_dac_pkg::code_t  in_nxt;

         assign sel    = write_hit & ((addr_field == 3'(ch)) | (addr_field == `ADDR_ALL));
         assign in_nxt = sel ? data_field : in_reg_r[ch];

         always_ff @(posedge clock) begin
            if (sys_rst) begin
               in_reg_r[ch] <= `CODE_RESET;
            end else if (clk_en) begin
               in_reg_r[ch] <= in_nxt;                             // RULE3
            end
         end

         // clear beats any pending load; a write meeting a load edge takes the new data
         always_ff @(posedge clock) begin
            if (sys_rst) begin
               conv_reg_r[ch] <= `CODE_RESET;                      // RULE18
            end else if (clk_en) begin
               if (clear_act) begin
                  conv_reg_r[ch] <= clear_code;                    // RULE10 RULE20
               end else if (load_fall) begin
                  conv_reg_r[ch] <= in_nxt;                        // RULE8
               end else if (sel & load_low) begin
                  conv_reg_r[ch] <= in_nxt;                        // RULE6 RULE7
               end
            end
         end

         // level is the code as straight binary: 0 is zero-scale, 0x8000 half-scale
         always_ff @(posedge clock) begin
            if (sys_rst) begin
               chan_level[ch] <= `CODE_RESET;
            end else if (clk_en) begin
               chan_level[ch] <= twos_mode ? (conv_reg_r[ch] ^ `SIGN_FLIP)
                                           : conv_reg_r[ch];       // RULE11 RULE13 RULE14
            end
         end

         assign chan_code[ch] = conv_reg_r[ch];
      end
   endgenerate

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         write_done  <= 1'b0;
         frame_error <= 1'b0;
      end else if (clk_en) begin
         write_done  <= write_hit;
         frame_error <= frame_rise & ~frame_ok_r;                  // RULE17
      end
   end

endmodule : quad_dac_device
`default_nettype wire

/* File: design/quad_dac_host.sv */
// serial host for the quad converter: makes the link clock, frames words, drives load and clear
`include "quad_dac_map.svh"
`default_nettype none
module quad_dac_host (
   input  wire logic         clock,
   input  wire logic         sys_rst,
   input  wire logic         clk_en,
   quad_dac_link.host        link,
   input  wire logic         req,
   input  wire logic [23:0]  tx_word,
   output logic              ready,
   input  wire logic         load_req,
   input  wire logic         clear_req,
   output logic [23:0]       rx_word,
   output logic              rx_valid
);

   localparam logic [3:0] HALF_CYC = 4'(`SCLK_HALF);
   localparam logic [3:0] GAP_CYC  = 4'(`FRAME_HIGH_CYC);

   quad_dac_pkg::host_state_t state_r;
   logic [3:0]           div_r;
   logic [4:0]           bit_r;
   quad_dac_pkg::word_t  tx_sh_r;
   quad_dac_pkg::word_t  rx_sh_r;
   logic                 frame_n_r;
   logic                 sclk_r;
   logic                 sdi_r;
   logic                 load_n_r;
   logic                 clear_n_r;
   logic                 load_pend_r;
   logic                 sdo_s1_r;
   logic                 sdo_s2_r;
   logic                 half_done;

   assign half_done = (div_r == HALF_CYC - 4'h1);
   assign ready     = (state_r == quad_dac_pkg::HS_IDLE) & ~load_pend_r;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sdo_s1_r <= 1'b0;
         sdo_s2_r <= 1'b0;
      end else if (clk_en) begin
         sdo_s1_r <= link.serial_out;
         sdo_s2_r <= sdo_s1_r;
      end
   end

   // a load request arriving as the previous one is taken is kept
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         load_pend_r <= 1'b0;
      end else if (clk_en) begin
         load_pend_r <= load_req | (load_pend_r & (state_r != quad_dac_pkg::HS_IDLE));
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         clear_n_r <= 1'b1;
      end else if (clk_en) begin
         clear_n_r <= ~clear_req;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_r   <= quad_dac_pkg::HS_IDLE;
         div_r     <= 4'h0;
         bit_r     <= 5'h00;
         tx_sh_r   <= '0;
         rx_sh_r   <= '0;
         frame_n_r <= 1'b1;
         sclk_r    <= 1'b1;
         sdi_r     <= 1'b0;
         load_n_r  <= 1'b1;
         rx_word   <= '0;
         rx_valid  <= 1'b0;
      end else if (clk_en) begin
         rx_valid <= 1'b0;
         div_r    <= div_r + 4'h1;
         case (state_r)
            quad_dac_pkg::HS_IDLE: begin
               div_r <= 4'h0;
               bit_r <= 5'h00;
               if (load_pend_r) begin
                  load_n_r <= 1'b0;                                // RULE19
                  state_r  <= quad_dac_pkg::HS_LOAD;
               end else if (req) begin
                  tx_sh_r   <= tx_word;
                  sdi_r     <= tx_word[`WORD_BITS-1];              // RULE16
                  frame_n_r <= 1'b0;                               // RULE1
                  state_r   <= quad_dac_pkg::HS_HIGH;
               end
            end
            quad_dac_pkg::HS_HIGH: begin
               if (half_done) begin
                  div_r   <= 4'h0;
                  sclk_r  <= 1'b0;                                 // RULE4
                  bit_r   <= bit_r + 5'h01;
                  rx_sh_r <= {rx_sh_r[`WORD_BITS-2:0], sdo_s2_r};
                  state_r <= quad_dac_pkg::HS_LOW;
               end
            end
            quad_dac_pkg::HS_LOW: begin
               if (half_done) begin
                  div_r  <= 4'h0;
                  sclk_r <= 1'b1;
                  if (bit_r == `BIT_COUNT_FULL) begin
                     state_r <= quad_dac_pkg::HS_TAIL;             // RULE17
                  end else begin
                     tx_sh_r <= {tx_sh_r[`WORD_BITS-2:0], 1'b0};
                     sdi_r   <= tx_sh_r[`WORD_BITS-2];             // RULE5
                     state_r <= quad_dac_pkg::HS_HIGH;
                  end
               end
            end
            quad_dac_pkg::HS_TAIL: begin
               if (half_done) begin
                  div_r     <= 4'h0;
                  frame_n_r <= 1'b1;
                  rx_word   <= rx_sh_r;
                  rx_valid  <= 1'b1;
                  state_r   <= quad_dac_pkg::HS_GAP;
               end
            end
            quad_dac_pkg::HS_LOAD: begin
               if (half_done) begin
                  div_r    <= 4'h0;
                  load_n_r <= 1'b1;
                  state_r  <= quad_dac_pkg::HS_GAP;
               end
            end
            quad_dac_pkg::HS_GAP: begin
               if (div_r == GAP_CYC - 4'h1) begin
                  state_r <= quad_dac_pkg::HS_IDLE;
               end
            end
            default: begin
               state_r <= quad_dac_pkg::HS_IDLE;
            end
         endcase
      end
   end

   assign link.frame_n       = frame_n_r;
   assign link.sclk          = sclk_r;
   assign link.serial_in     = sdi_r;
   assign link.load_strobe_n = load_n_r;                           // RULE9
   assign link.clear_n       = clear_n_r;

endmodule : quad_dac_host
`default_nettype wire

/* File: design/quad_dac_link.sv */
// pins between the serial host and the quad converter
`default_nettype none
interface quad_dac_link;
   logic frame_n;
   logic sclk;
   logic serial_in;
   logic serial_out;
   logic load_strobe_n;
   logic clear_n;
   modport device (
      input  frame_n,
      input  sclk,
      input  serial_in,
      input  load_strobe_n,
      input  clear_n,
      output serial_out
   );
   modport host (
      output frame_n,
      output sclk,
      output serial_in,
      output load_strobe_n,
      output clear_n,
      input  serial_out
   );
endinterface : quad_dac_link
`default_nettype wire

/* File: design/quad_dac_map.svh */
// offsets, field positions, reset values and timing counts of the quad converter serial link
// What this block does
// RULE1 - low frame sync brackets every serial transfer
// RULE2 - shift serial input on each falling clock
// RULE3 - frame sync rise latches word into register
// RULE4 - host serial clock at most 30 MHz
// RULE5 - host keeps serial input stable at falling edge
// RULE6 - load held low updates at frame rise
// RULE7 - load high defers output until load falls
// RULE8 - load falling updates all four outputs together
// RULE9 - load strobe always driven, never floating
// RULE10 - clear forces zero-scale or midscale code
// RULE11 - bipolar coding: high offset binary, low twos
// RULE12 - unipolar ranges always straight binary
// RULE13 - half-scale is 0x8000 straight, 0x0000 twos
// RULE14 - zero-scale is 0x0000 straight, 0x8000 twos
// RULE15 - serial output changes on rising clock edge
// RULE16 - 24-bit word, msb first, fixed field layout
// RULE17 - exactly 24 falling edges, else word invalid
// RULE18 - converter registers reset to 0x0000
// RULE19 - host pulses load only while frame high
// RULE20 - clear independent of serial clock, overrides load
// RULE21 - narrow channels use top data bits
`ifndef QUAD_DAC_MAP_SVH
`define QUAD_DAC_MAP_SVH

`define WORD_BITS        24
`define RW_BIT           23
`define REG_MSB          21
`define REG_LSB          19
`define ADDR_MSB         18
`define ADDR_LSB         16
`define DATA_BITS        16
`define CHANNELS         4
`define RESOLUTION       16
`define REG_SEL_CONV     3'h0
`define ADDR_ALL         3'h4
`define CODE_RESET       16'h0000
`define CODE_STRAIGHT_ZS 16'h0000
`define CODE_STRAIGHT_MS 16'h8000
`define SIGN_FLIP        16'h8000
`define BIT_COUNT_LIMIT  5'h19
`define BIT_COUNT_FULL   5'h18

`define CLK_MHZ          50
`define SCLK_MAX_MHZ     30
`define SCLK_HALF_MIN    ((`CLK_MHZ + 2 * `SCLK_MAX_MHZ - 1) / (2 * `SCLK_MAX_MHZ))
`define SCLK_HALF        4
`define FRAME_HIGH_NS    200
`define FRAME_HIGH_CYC   ((`FRAME_HIGH_NS * `CLK_MHZ + 999) / 1000)

`endif

/* File: design/quad_dac_pkg.sv */
// types shared by both ends of the quad converter serial link
`default_nettype none
package quad_dac_pkg;
   typedef logic [15:0] code_t;
   typedef logic [23:0] word_t;
   typedef enum logic [2:0] {
      HS_IDLE,
      HS_HIGH,
      HS_LOW,
      HS_TAIL,
      HS_GAP,
      HS_LOAD
   } host_state_t;
endpackage : quad_dac_pkg
`default_nettype wire

/* File: tb/quad_dac_serial_update_assertions.sv */
// checker for frame, clock, data and load timing on the wires between host and converter
`default_nettype none
module quad_dac_serial_update_assertions (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic frame_n,
   input wire logic sclk,
   input wire logic serial_in,
   input wire logic serial_out,
   input wire logic load_strobe_n,
   input wire logic clear_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] falls_r;

   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);

   // saturates so that a runaway clock cannot wrap back to a legal count
   always_ff @(posedge clock) begin
      if (sys_rst || frame_n) begin
         falls_r <= 5'h00;
      end else if ($fell(sclk) && falls_r != 5'h1f) begin
         falls_r <= falls_r + 5'h01;
      end
   end

   property p_idle_clock;
      frame_n |-> sclk;
   endproperty
   a_idle_clock: assert property (p_idle_clock) else $error("link clock low outside a frame");
   property p_frame_gap;
      $rose(frame_n) |-> frame_n [*8] ##1 frame_n [*2];
   endproperty
   a_frame_gap: assert property (p_frame_gap) else $error("frame sync high time too short");
   property p_sclk_low;
      $fell(sclk) |-> (!sclk) [*4] ##1 sclk;
   endproperty
   a_sclk_low: assert property (p_sclk_low) else $error("link clock low phase wrong");
   property p_din_hold;
      !frame_n && $changed(serial_in) |-> $rose(sclk) || $fell(frame_n);
   endproperty
   a_din_hold: assert property (p_din_hold) else $error("serial input moved away from rising clock");
   property p_fall_count;
      $rose(frame_n) |-> falls_r == 5'h18;
   endproperty
   a_fall_count: assert property (p_fall_count) else $error("frame without 24 falling edges");
   property p_load_framed;
      !load_strobe_n |-> frame_n && $past(frame_n);
   endproperty
   a_load_framed: assert property (p_load_framed) else $error("load pulse inside a frame");
   property p_load_width;
      $fell(load_strobe_n) |-> (!load_strobe_n) [*4] ##1 load_strobe_n;
   endproperty
   a_load_width: assert property (p_load_width) else $error("load pulse width wrong");
   property p_sdo_edge;
      !frame_n && !$past(frame_n) && $changed(serial_out) |-> $rose(sclk);
   endproperty
   a_sdo_edge: assert property (p_sdo_edge) else $error("serial output moved off rising clock");

   c_clear: cover property (!clear_n);
endmodule : quad_dac_serial_update_assertions
`default_nettype wire

/* File: tb/tb_quad_dac_serial_update.sv */
// testbench: serial host against one converter, plus a bench-driven second converter
`default_nettype none
module tb_quad_dac_serial_update;
   timeunit 1ns;
   timeprecision 1ps;
   logic                clock;
   logic                sys_rst;
   logic                req;
   quad_dac_pkg::word_t tx_word;
   logic                ready;
   logic                load_req;
   logic                clear_req;
   logic                rx_valid;
   quad_dac_pkg::word_t rx_word;
   logic                coding_select;
   logic                bipolar_range;
   logic                clear_to_mid;
   logic [3:0][15:0]    chan_code;
   logic [3:0][15:0]    chan_level;
   logic [3:0][15:0]    code_b;
   logic                done_b;
   logic                error_b;
   int                  fail_count;
   int                  tests_run;

   quad_dac_link link ();
   quad_dac_link link_b ();

   quad_dac_host u_quad_dac_host (.clock(clock), .sys_rst(sys_rst), .clk_en(1'b1), .link(link), .req(req),
      .tx_word(tx_word), .ready(ready), .load_req(load_req), .clear_req(clear_req), .rx_word(rx_word),
      .rx_valid(rx_valid));
   quad_dac_device u_quad_dac_device (.clock(clock), .sys_rst(sys_rst), .clk_en(1'b1), .link(link),
      .coding_select(coding_select), .bipolar_range(bipolar_range), .clear_to_mid(clear_to_mid),
      .chan_code(chan_code), .chan_level(chan_level), .write_done(), .frame_error());
   // second converter faces the bench directly so that malformed frames can be sent
   quad_dac_device u_quad_dac_device_b (.clock(clock), .sys_rst(sys_rst), .clk_en(1'b1), .link(link_b),
      .coding_select(coding_select), .bipolar_range(bipolar_range), .clear_to_mid(clear_to_mid),
      .chan_code(code_b), .chan_level(), .write_done(done_b), .frame_error(error_b));
   quad_dac_serial_update_assertions u_quad_dac_serial_update_assertions (.clock(clock), .sys_rst(sys_rst),
      .frame_n(link.frame_n), .sclk(link.sclk), .serial_in(link.serial_in), .serial_out(link.serial_out),
      .load_strobe_n(link.load_strobe_n), .clear_n(link.clear_n));

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   task automatic check(input quad_dac_pkg::code_t seen, input quad_dac_pkg::code_t exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : complete_run

   // 0 ready, 1 host word done, 2 bench write accepted, 3 bench frame refused
   task automatic wait_for(input int which, input int limit);
      int   n;
      logic seen;
      n = 0;
      seen = 1'b0;
      while (seen !== 1'b1) begin
         @(negedge clock);
         seen = (which == 0) ? ready : (which == 1) ? rx_valid : (which == 2) ? done_b : error_b;
         n++;
         if (n > limit) begin
            fail_count++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, 1'b0, 1'b1);
            complete_run();
         end
      end
   endtask : wait_for

   task automatic host_write(input logic [2:0] ch, input quad_dac_pkg::code_t data);
      wait_for(0, 400);
      req = 1'b1;
      tx_word = {5'h00, ch, data};
      @(negedge clock);
      req = 1'b0;
      wait_for(1, 400);
      wait_for(0, 400);
   endtask : host_write

   task automatic host_load();
      load_req = 1'b1;
      @(negedge clock);
      load_req = 1'b0;
      repeat (4) @(negedge clock);
      wait_for(0, 100);
   endtask : host_load

   // bench link clock runs only inside the frame; data moves with the rising edge
   task automatic bench_frame(input quad_dac_pkg::word_t w, input int bits);
      link_b.frame_n = 1'b0;
      for (int i = 0; i < bits; i++) begin
         link_b.serial_in = (i < 24) ? w[23 - i] : ~w[0];
         #15 link_b.sclk = 1'b0;
         #15 link_b.sclk = 1'b1;
      end
      #15 link_b.frame_n = 1'b1;
      link_b.serial_in = ~link_b.serial_in;
   endtask : bench_frame

   task automatic test_deferred();
      for (int i = 0; i < 4; i++) check(chan_code[i], 16'h0000);
      host_write(3'h1, 16'h1234);
      host_write(3'h3, 16'hfedc);
      // the chained-out word is the previous frame, its first bit parked low
      check(rx_word[15:0], 16'h1234);
      check(16'(rx_word[23:16]), 16'h0001);
      check(chan_code[1], 16'h0000);
      check(chan_code[3], 16'h0000);
      host_load();
      check(chan_code[1], 16'h1234);
      check(chan_code[3], 16'hfedc);
      check(chan_code[0], 16'h0000);
      $display("test deferred load done");
   endtask : test_deferred

   task automatic test_coding();
      logic [1:0]          mode [4] = '{2'h2, 2'h2, 2'h3, 2'h0};
      quad_dac_pkg::code_t code [4] = '{16'h0000, 16'h8000, 16'ha5c3, 16'h8001};
      quad_dac_pkg::code_t lvl [4] = '{16'h8000, 16'h0000, 16'ha5c3, 16'h8001};
      for (int i = 0; i < 4; i++) begin
         bipolar_range = mode[i][1];
         coding_select = mode[i][0];
         host_write(3'h4, code[i]);
         host_load();
         for (int c = 0; c < 4; c++) check(chan_level[c], lvl[i]);
      end
      $display("test coding done");
   endtask : test_coding

   task automatic test_clear();
      bipolar_range = 1'b1;
      coding_select = 1'b1;
      host_write(3'h2, 16'h0bad);
      clear_to_mid = 1'b1;
      clear_req = 1'b1;
      repeat (8) @(negedge clock);
      for (int c = 0; c < 4; c++) check(chan_code[c], 16'h8000);
      host_load();
      check(chan_code[2], 16'h8000);
      clear_to_mid = 1'b0;
      repeat (8) @(negedge clock);
      check(chan_code[1], 16'h0000);
      clear_req = 1'b0;
      repeat (8) @(negedge clock);
      check(chan_code[2], 16'h0000);
      host_load();
      check(chan_code[2], 16'h0bad);
      check(chan_code[0], 16'h8001);
      $display("test clear done");
   endtask : test_clear

   task automatic test_bench_link();
      bench_frame({5'h00, 3'h0, 16'ha5c3}, 24);
      wait_for(2, 40);
      check(code_b[0], 16'ha5c3);
      for (int k = 0; k < 2; k++) begin
         repeat (12) @(negedge clock);
         bench_frame({5'h00, 3'h0, 16'h1111}, 23 + 2 * k);
         wait_for(3, 40);
         check(code_b[0], 16'ha5c3);
      end
      $display("test bench link done");
   endtask : test_bench_link

   initial begin
      fail_count = 0;
      tests_run = 0;
      sys_rst = 1'b1;
      req = 1'b0;
      tx_word = 24'h000000;
      load_req = 1'b0;
      clear_req = 1'b0;
      coding_select = 1'b0;
      bipolar_range = 1'b1;
      clear_to_mid = 1'b0;
      link_b.frame_n = 1'b0;
      link_b.sclk = 1'b1;
      link_b.serial_in = 1'b0;
      link_b.load_strobe_n = 1'b0;
      link_b.clear_n = 1'b1;
      repeat (20) @(negedge clock);
      // a clean rising edge clears the far converter's bit counter before its first frame
      link_b.frame_n = 1'b1;
      sys_rst = 1'b0;
      repeat (4) @(negedge clock);
      test_deferred();
      test_coding();
      test_clear();
      test_bench_link();
      complete_run();
   end
endmodule : tb_quad_dac_serial_update
`default_nettype wire
